// ---- rtl/bct_pkg.sv ----
// Package with constants and types shared by the bridge cycle timing block.
package bct_pkg;
  // Clock rate and time bases.
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned FAST_STEP_NS     = 2000;
  localparam int unsigned FAST_STEP_CYC    = FAST_STEP_NS * CLK_MHZ / 1000;
  localparam int unsigned SLOW_STEP_US     = 100;
  localparam int unsigned SLOW_TICK_KHZ    = 10;
  localparam int unsigned SLOW_DIV_CYC     = CLK_MHZ * 1000 / SLOW_TICK_KHZ;
  // Register offsets, all word aligned.
  localparam logic [7:0]  OFS_CFG1         = 8'h04;
  localparam logic [7:0]  OFS_CFG2         = 8'h08;
  localparam logic [7:0]  OFS_CFG3         = 8'h0C;
  localparam logic [7:0]  OFS_GAIN1        = 8'h10;
  localparam logic [7:0]  OFS_GAIN2        = 8'h14;
  localparam logic [7:0]  OFS_GAIN3        = 8'h18;
  localparam logic [7:0]  OFS_GAIN4        = 8'h1C;
  localparam logic [7:0]  OFS_TEMPCO       = 8'h20;
  localparam logic [7:0]  OFS_CTRL         = 8'h24;
  localparam logic [7:0]  OFS_STAT         = 8'h28;
  localparam logic [7:0]  OFS_IRQ_STAT     = 8'h2C;
  localparam logic [7:0]  OFS_IRQ_MASK     = 8'h30;
  localparam logic [7:0]  OFS_HB_SEL       = 8'h34;
  localparam logic [7:0]  OFS_HB_RES       = 8'h38;
  localparam logic [7:0]  OFS_TOTAL_RES    = 8'h3C;
  // Field positions.
  localparam int unsigned SPAN_MODE_BIT    = 6;
  localparam int unsigned CYTIME_LSB       = 4;
  localparam int unsigned CYTIME_W         = 10;
  localparam int unsigned TOPO_LSB         = 0;
  localparam int unsigned CTRL_RUN_BIT     = 0;
  localparam int unsigned CTRL_STRETCH_BIT = 1;
  localparam int unsigned IRQ_W            = 2;
  localparam int unsigned IRQ_CYCLE_BIT    = 0;
  localparam int unsigned IRQ_OVF_BIT      = 1;
  localparam int unsigned GAIN_W           = 24;
  localparam int unsigned RES_W            = 24;
  localparam int unsigned NUM_HB           = 4;
  // Reset values.
  localparam logic [31:0] RST_CFG          = 32'h0000_0000;
  localparam logic [1:0]  RST_TOPO         = 2'h1;
  localparam logic [GAIN_W-1:0] RST_GAIN   = 24'h10_0000;
  localparam logic [31:0] RST_ZERO         = 32'h0000_0000;
  // Bridge topology codes.
  localparam logic [1:0]  TOPO_HALF        = 2'h0;
  localparam logic [1:0]  TOPO_FULL        = 2'h1;
  localparam logic [1:0]  TOPO_QUATTRO     = 2'h3;
  typedef enum logic [1:0] {
    BCT_T_HALF,
    BCT_T_FULL,
    BCT_T_QUAD
  } bct_topo_t;
endpackage

// ---- rtl/bct_tick_gen.sv ----
// Time base that gives one tick per count of the cycle field.
`timescale 1ns/100ps
`default_nettype none
module bct_tick_gen (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic stretched,
  output logic      tick
);
  import bct_pkg::*;

  logic [15:0] fastCnt;
  logic [15:0] slowCnt;
  wire         fastWrap = (fastCnt == 16'(FAST_STEP_CYC - 1));
  wire         slowWrap = (slowCnt == 16'(SLOW_DIV_CYC - 1));

  // Fast step of 2 us, and slow step of 100 us from the 10 kHz base.
  assign tick = stretched ? slowWrap : fastWrap;

  // Both dividers run freely so a mode change picks up a live base.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fastCnt <= 16'h0000;
      slowCnt <= 16'h0000;
    end else begin
      fastCnt <= fastWrap ? 16'h0000 : fastCnt + 16'h0001;
      slowCnt <= slowWrap ? 16'h0000 : slowCnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/bct_cycle_timer.sv ----
// Cycle interval timer that issues one start pulse per interval.
`timescale 1ns/100ps
`default_nettype none
module bct_cycle_timer (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic [9:0] cycleTime,
  output logic            startPulse,
  output logic [9:0]      elapsed
);
  logic [9:0] remain;
  wire        expire = run && tick && (remain <= 10'h001);

  // Reload from the field at each expiry and start the next discharge.
  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      remain     <= 10'h000;
      elapsed    <= 10'h000;
      startPulse <= 1'b0;
    end else begin
      startPulse <= expire;
      if (expire) begin
        remain  <= cycleTime;
        elapsed <= 10'h000;
      end else if (tick) begin
        remain  <= remain - 10'h001;
        elapsed <= elapsed + 10'h001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/bct_bridge_timing.sv ----
// Bridge topology, gain factors and discharge cycle timing with registers.
//
// Notes on behaviour
// - Topology 1 runs one full bridge.
// - Topology 3 gives four half-bridge results plus total.
// - Each half bridge has its own writable gain.
// - Cycle field counts 2 us steps normally.
// - Stretched mode counts 100 us steps.
// - Overflow when interval not above discharge time.
// - Each interval starts one discharge then recharge.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module bct_bridge_timing (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic [7:0]                   regAddr,
  input  wire logic [31:0]                  regWdata,
  input  wire logic                         regWr,
  input  wire logic                         regRd,
  output logic [31:0]                       regRdata,
  input  wire logic                         dischargeDone,
  input  wire logic [bct_pkg::RES_W-1:0]    portResult,
  output logic                              dischargeStart,
  output logic [1:0]                        activePort,
  output logic                              spanMode,
  output logic                              quattroMode,
  output logic                              irq
);
  import bct_pkg::*;

  // Configuration and gain registers.
  logic [31:0]       cfg1;
  logic [31:0]       cfg2;
  logic [31:0]       cfg3;
  logic [GAIN_W-1:0] gainFactor [NUM_HB];
  logic [31:0]       gainTempCoefficient;
  logic [1:0]        ctrl;
  logic [IRQ_W-1:0]  irqStat;
  logic [IRQ_W-1:0]  irqMask;
  logic [1:0]        hbSel;
  logic [RES_W-1:0]  hbResult [NUM_HB];
  logic [RES_W-1:0]  totalResult;
  logic [9:0]        lastDischarge;
  logic              measuring;
  logic              overflow;
  logic [1:0]        portIdx;
  bct_topo_t         topo;

  // Field extraction.
  wire [9:0]   cycleTime   = cfg2[CYTIME_LSB +: CYTIME_W];
  wire [1:0]   topoField   = cfg3[TOPO_LSB +: 2];
  wire         run         = ctrl[CTRL_RUN_BIT];
  wire         stretched   = ctrl[CTRL_STRETCH_BIT];
  wire         tick;
  wire [9:0]   elapsed;
  wire         startPulse;

  // Topology decode; an unused code behaves as a full bridge.
  always_comb begin
    case (topoField)
      TOPO_HALF:    topo = BCT_T_HALF;
      TOPO_QUATTRO: topo = BCT_T_QUAD;
      default:      topo = BCT_T_FULL;
    endcase
  end

  // Index of the last port cycled per sample for the selected topology.
  function automatic logic [1:0] lastPort(input bct_topo_t t);
    case (t)
      BCT_T_HALF: lastPort = 2'h1;
      BCT_T_QUAD: lastPort = 2'h3;
      default:    lastPort = 2'h3;
    endcase
  endfunction

  // Signed product of a result and its gain, gain in 4.20 fixed point.
  function automatic logic [RES_W-1:0] scale(input logic [RES_W-1:0] r,
                                             input logic [GAIN_W-1:0] g);
    logic signed [47:0] p;
    p     = $signed(r) * $signed(g);
    scale = p[43:20];
  endfunction

  assign spanMode    = cfg1[SPAN_MODE_BIT];
  assign quattroMode = (topo == BCT_T_QUAD);
  assign activePort  = portIdx;
  assign irq         = |(irqStat & irqMask);

  // In all modes the interval covers discharge and recharge, so a
  // discharge still running at the next start is an overflow. In
  // stretched mode the field also spans from start to start.
  wire ovfEvent = startPulse && measuring;
  wire gainIdxOk = 1'b1;

  bct_tick_gen u_tick (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .stretched (stretched),
    .tick      (tick)
  );

  bct_cycle_timer u_timer (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .run        (run),
    .tick       (tick),
    .cycleTime  (cycleTime),
    .startPulse (startPulse),
    .elapsed    (elapsed)
  );

  assign dischargeStart = startPulse;

  // Register writes to the configuration, gain, control, mask and select registers.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg1                <= RST_CFG;
      cfg2                <= RST_CFG;
      cfg3                <= {30'h0000_0000, RST_TOPO};
      gainTempCoefficient <= RST_ZERO;
      ctrl                <= 2'h0;
      irqMask             <= '0;
      hbSel               <= 2'h0;
      for (int i = 0; i < NUM_HB; i++) begin
        gainFactor[i] <= RST_GAIN;
      end
    end else if (regWr) begin
      case (regAddr)
        OFS_CFG1:     cfg1 <= regWdata;
        OFS_CFG2:     cfg2 <= regWdata;
        OFS_CFG3:     cfg3 <= regWdata;
        OFS_GAIN1:    gainFactor[0] <= regWdata[GAIN_W-1:0];
        OFS_GAIN2:    gainFactor[1] <= regWdata[GAIN_W-1:0];
        OFS_GAIN3:    gainFactor[2] <= regWdata[GAIN_W-1:0];
        OFS_GAIN4:    gainFactor[3] <= regWdata[GAIN_W-1:0];
        OFS_TEMPCO:   gainTempCoefficient <= regWdata;
        OFS_CTRL:     ctrl <= regWdata[1:0];
        OFS_IRQ_MASK: irqMask <= regWdata[IRQ_W-1:0];
        OFS_HB_SEL:   hbSel <= regWdata[1:0];
        default:      ;
      endcase
    end
  end

  // Sticky status; a new event wins over a write-one clear.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqStat <= '0;
    end else begin
      for (int b = 0; b < IRQ_W; b++) begin
        if ((b == IRQ_CYCLE_BIT && startPulse) || (b == IRQ_OVF_BIT && ovfEvent)) begin
          irqStat[b] <= 1'b1;
        end else if (regWr && regAddr == OFS_IRQ_STAT && regWdata[b]) begin
          irqStat[b] <= 1'b0;
        end
      end
    end
  end

  // Discharge tracking, port stepping and result capture.
  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      measuring     <= 1'b0;
      overflow      <= 1'b0;
      portIdx       <= 2'h0;
      lastDischarge <= 10'h000;
      totalResult   <= '0;
      for (int i = 0; i < NUM_HB; i++) begin
        hbResult[i] <= '0;
      end
    end else begin
      if (startPulse) begin
        measuring <= 1'b1;
        overflow  <= ovfEvent;
      end else if (dischargeDone) begin
        measuring     <= 1'b0;
        lastDischarge <= elapsed;
      end
      if (dischargeDone && measuring) begin
        hbResult[portIdx] <= scale(portResult, gainFactor[portIdx]);
        portIdx <= (portIdx == lastPort(topo)) ? 2'h0 : portIdx + 2'h1;
        if (portIdx == lastPort(topo)) begin
          totalResult <= hbResult[0] + hbResult[1] + hbResult[2]
                         + scale(portResult, gainFactor[portIdx]);
        end
      end
    end
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge ref_clk) begin
    if (rst || !regRd) begin
      regRdata <= 32'h0000_0000;
    end else begin
      case (regAddr)
        OFS_CFG1:      regRdata <= cfg1;
        OFS_CFG2:      regRdata <= cfg2;
        OFS_CFG3:      regRdata <= cfg3;
        OFS_GAIN1:     regRdata <= {8'h00, gainFactor[0]};
        OFS_GAIN2:     regRdata <= {8'h00, gainFactor[1]};
        OFS_GAIN3:     regRdata <= {8'h00, gainFactor[2]};
        OFS_GAIN4:     regRdata <= {8'h00, gainFactor[3]};
        OFS_TEMPCO:    regRdata <= gainTempCoefficient;
        OFS_CTRL:      regRdata <= {30'h0000_0000, ctrl};
        OFS_STAT:      regRdata <= {16'h0000, lastDischarge, portIdx,
                                    1'b0, gainIdxOk, overflow, measuring};
        OFS_IRQ_STAT:  regRdata <= {30'h0000_0000, irqStat};
        OFS_IRQ_MASK:  regRdata <= {30'h0000_0000, irqMask};
        OFS_HB_SEL:    regRdata <= {30'h0000_0000, hbSel};
        OFS_HB_RES:    regRdata <= {8'h00, hbResult[hbSel]};
        OFS_TOTAL_RES: regRdata <= {8'h00, totalResult};
        default:       regRdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- bench/bct_bridge_timing_sva.sv ----
// Port timing checker for the bridge cycle timing block.
`timescale 1ns/100ps
`default_nettype none
module bct_bridge_timing_sva (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  input wire logic        dischargeDone,
  input wire logic        dischargeStart,
  input wire logic [1:0]  activePort,
  input wire logic        spanMode,
  input wire logic        quattroMode,
  input wire logic        irq
);
  import bct_pkg::*;
  logic [15:0] gapCnt;
  logic        gapSeen;
  wire         ctrlWr = regWr && regAddr == OFS_CTRL;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Counts cycles since the last start; a control write forgets that start.
  always_ff @(posedge ref_clk) begin
    if (rst || ctrlWr) begin
      gapCnt  <= 16'h0000;
      gapSeen <= 1'b0;
    end else if (dischargeStart) begin
      gapCnt  <= 16'h0000;
      gapSeen <= 1'b1;
    end else if (gapCnt != 16'hFFFF) begin
      gapCnt <= gapCnt + 16'h0001;
    end
  end
  // A write strobe to one register.
  sequence s_cfg(a);
    regWr && regAddr == a;
  endsequence
  a_rdata_idle_zero: assert property (
    !$past(regRd) |-> regRdata == 32'h0) else $error("read data outside its slot");
  a_start_single: assert property (
    dischargeStart |=> !dischargeStart) else $error("start pulse too long");
  a_start_spacing: assert property (
    dischargeStart && gapSeen |-> gapCnt >= 16'h01F3) else $error("starts too close");
  a_topo_quattro: assert property (
    s_cfg(OFS_CFG3) |=> quattroMode == ($past(regWdata[1:0]) == TOPO_QUATTRO))
    else $error("quattro flag does not follow topology");
  a_span_follows: assert property (
    s_cfg(OFS_CFG1) |=> spanMode == $past(regWdata[SPAN_MODE_BIT]))
    else $error("span flag does not follow its bit");
  a_irq_mask_off: assert property (
    s_cfg(OFS_IRQ_MASK) ##0 regWdata[1:0] == 2'h0 |-> ##2 !irq)
    else $error("masked interrupt still high");
  a_port_advance: assert property (
    dischargeDone |=> activePort != $past(activePort)) else $error("port did not advance");
  a_reset_quiet: assert property (
    $past(rst) |-> !dischargeStart && !irq && !quattroMode && !spanMode && activePort == 2'h0)
    else $error("outputs not quiet after reset");
endmodule
bind bct_bridge_timing bct_bridge_timing_sva bct_bridge_timing_sva_i (
  .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .dischargeDone(dischargeDone),
  .dischargeStart(dischargeStart), .activePort(activePort), .spanMode(spanMode),
  .quattroMode(quattroMode), .irq(irq));
`default_nettype wire

// ---- bench/test_bct_bridge_timing.sv ----
// Self-checking bench for the bridge cycle timing block.
`timescale 1ns/100ps
`default_nettype none
module test_bct_bridge_timing;
  import bct_pkg::*;
  logic             ref_clk = 1'b0;
  logic             rst = 1'b1;
  logic [7:0]       regAddr = 8'h00;
  logic [31:0]      regWdata = 32'h0;
  logic             regWr = 1'b0;
  logic             regRd = 1'b0;
  logic             dischargeDone = 1'b0;
  logic [RES_W-1:0] portResult = 24'h0;
  wire  [31:0]      regRdata;
  wire              dischargeStart, spanMode, quattroMode, irq;
  wire  [1:0]       activePort;
  int               bad_count = 0;
  int               compares = 0;
  logic [31:0]      seed = 32'h5F;
  int               gainQ[$];
  logic [RES_W-1:0] lastRes = 24'h0;
  int               lastHb = 0;
  logic [1:0]       topo [3] = '{TOPO_HALF, TOPO_QUATTRO, TOPO_FULL};
  bct_bridge_timing bct_bridge_timing_i (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .dischargeDone(dischargeDone),
    .portResult(portResult), .dischargeStart(dischargeStart), .activePort(activePort),
    .spanMode(spanMode), .quattroMode(quattroMode), .irq(irq));
  // Free-running clock of 4 ns period.
  always #2 ref_clk = ~ref_clk;
  // Xorshift source of random values.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Model of a half-bridge result: signed product scaled by a 4.20 gain.
  function automatic logic [31:0] mdl(logic [23:0] r, logic [23:0] g);
    longint pr;
    pr = longint'($signed(r)) * longint'($signed(g));
    return {8'h00, pr[43:20]};
  endfunction
  // Comparison that counts and reports mismatches.
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("compares %0d, bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Register write and read cycles of the plain port.
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(string nm, logic [7:0] a, logic [31:0] e, logic [31:0] m);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(nm, e & m, regRdata & m);
  endtask
  // Waits for a start, answers it if asked, and measures the interval to the next one.
  task automatic gap(int e, bit ans);
    int n;
    int p;
    logic [RES_W-1:0] r;
    n = 0;
    while (dischargeStart !== 1'b1) begin
      @(posedge ref_clk);
      #1 n++;
      if (n > 60000) chk("start wait", 32'h1, 32'h0);
      if (n > 60000) final_report();
    end
    p = int'(activePort);
    n = 0;
    do begin
      @(posedge ref_clk);
      r = RES_W'(xs());
      dischargeDone <= ans && n == 8;
      portResult    <= r;
      if (ans && n == 8) begin
        lastRes = r;
        lastHb  = p;
      end
      #1 n++;
      if (ans && n == 12) chk("activePort", 32'((p + 1) % 4), 32'(activePort));
      if (n > 60000) chk("start wait", 32'h1, 32'h0);
      if (n > 60000) final_report();
    end while (dischargeStart !== 1'b1);
    chk("interval", 32'(e), 32'(n));
  endtask
  // Main sequence of scenarios.
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd("cfg3", OFS_CFG3, 32'h1, 32'hFFFF_FFFF);
    rd("unmapped", 8'h00, 32'h0, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) begin
      rd("gain reset", OFS_GAIN1 + 8'(4 * i), 32'(RST_GAIN), 32'h00FF_FFFF);
      gainQ.push_back(i == 0 ? 32'h10_0000 : i == 1 ? 32'hF0_0000 : xs() & 32'hFF_FFFF);
      wr(OFS_GAIN1 + 8'(4 * i), gainQ[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rd("gain", OFS_GAIN1 + 8'(4 * i), gainQ[i], 32'h00FF_FFFF);
    end
    wr(OFS_TEMPCO, 32'h000C_0000);
    rd("tempco", OFS_TEMPCO, 32'h000C_0000, 32'hFFFF_FFFF);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CFG3, 32'(topo[i]));
      @(posedge ref_clk);
      #1 chk("quattroMode", 32'(topo[i] == TOPO_QUATTRO), 32'(quattroMode));
    end
    for (int b = 1; b >= 0; b--) begin
      wr(OFS_CFG1, 32'(b) << SPAN_MODE_BIT);
      @(posedge ref_clk);
      #1 chk("spanMode", 32'(b), 32'(spanMode));
    end
    wr(OFS_CFG2, 32'h30);
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_CTRL, 32'h1);
    gap(3 * FAST_STEP_CYC, 1'b1);
    gap(3 * FAST_STEP_CYC, 1'b1);
    chk("irq", 32'h1, 32'(irq));
    wr(OFS_HB_SEL, 32'(lastHb));
    rd("hbResult", OFS_HB_RES, mdl(lastRes, 24'(gainQ[lastHb])), 32'h00FF_FFFF);
    wr(OFS_IRQ_STAT, 32'h3);
    @(posedge ref_clk);
    #1 chk("irq", 32'h0, 32'(irq));
    wr(OFS_IRQ_MASK, 32'h2);
    gap(3 * FAST_STEP_CYC, 1'b0);
    rd("overflow", OFS_IRQ_STAT, 32'h2, 32'h2);
    chk("irq", 32'h1, 32'(irq));
    wr(OFS_IRQ_MASK, 32'h0);
    @(posedge ref_clk);
    #1 chk("irq", 32'h0, 32'(irq));
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CFG2, 32'h10);
    wr(OFS_CTRL, 32'h3);
    gap(SLOW_DIV_CYC, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
